// [core/ext_interrupt_period_measure.sv]
// External interrupt pins, request flags and period measurement control
`timescale 1ns/1ps
module ext_interrupt_period_measure (
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire logic                        ext_irq_pin0,
	input  wire logic                        ext_irq_pin1,
	input  wire logic                        counter_input_pin,
	input  wire logic                        timer1_running,
	input  wire logic                        timer1_underflow,
	input  wire irq_meas_pkg::instr_type     instr,
	input  wire irq_meas_pkg::reg_write_type reg_write,
	output irq_meas_pkg::ctl_state_type      ctl_state,
	output logic                             ext0_request_flag,
	output logic                             ext1_request_flag,
	output logic                             timer1_request_flag,
	output logic [2:0]                       irq_request,
	output logic                             skip_next,
	output logic                             meas_restart,
	output logic                             meas_capture,
	output logic                             ram_backup_enter,
	output logic                             keyon_wakeup
);
	typedef enum logic [1:0] {M_IDLE, M_WAIT_FIRST, M_TIMING} meas_state_type;

	logic [3:0]     pin0_q, pin0_d, pin1_q, pin1_d, wake_q, wake_d;
	logic [3:0]     irq_en_q, irq_en_d, meas_ctl_q, meas_ctl_d;
	logic [2:0]     flags_q, flags_d, flag_set, flag_clr;
	meas_state_type meas_q, meas_d;
	logic           restart_q, restart_d, capture_q, capture_d;
	logic           armed_q, armed_d, backup_q, backup_d, skip_q, skip_d;
	logic           wakeup_q, wakeup_d;
	logic [2:0]     det_pin, det_en, det_rise, det_lvl, det_edge;
	logic           meas_edge, meas_hit, meas_stop, meas_active;

	// Control registers written by transfer instructions
	always_comb begin
		pin0_d = pin0_q;
		pin1_d = pin1_q;
		irq_en_d   = irq_en_q;
		meas_ctl_d = meas_ctl_q;
		wake_d = wake_q;
		if (reg_write.valid) begin
			case (reg_write.sel)
				irq_meas_pkg::SEL_PIN0:    pin0_d     = reg_write.data;
				irq_meas_pkg::SEL_PIN1:    pin1_d     = reg_write.data;
				irq_meas_pkg::SEL_ENABLE:  irq_en_d   = reg_write.data;
				irq_meas_pkg::SEL_MEASURE: meas_ctl_d = reg_write.data;
				irq_meas_pkg::SEL_WAKEUP:  wake_d = reg_write.data;
				default:                   wake_d = wake_q;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin0_q <= irq_meas_pkg::CTL_RESET;
			pin1_q <= irq_meas_pkg::CTL_RESET;
			irq_en_q   <= irq_meas_pkg::CTL_RESET;
			meas_ctl_q <= irq_meas_pkg::CTL_RESET;
			wake_q <= irq_meas_pkg::CTL_RESET;
		end else begin
			pin0_q <= pin0_d;
			pin1_q <= pin1_d;
			irq_en_q   <= irq_en_d;
			meas_ctl_q <= meas_ctl_d;
			wake_q <= wake_d;
		end
	end

	// Pin 0, pin 1 and the counter pin; the counter pin always looks for rising edges
	assign det_pin  = {counter_input_pin, ext_irq_pin1, ext_irq_pin0};
	assign det_en   = {1'b1, pin1_q[irq_meas_pkg::PIN_ENABLE_BIT],
		pin0_q[irq_meas_pkg::PIN_ENABLE_BIT]};
	assign det_rise = {1'b1, pin1_q[irq_meas_pkg::PIN_WAVE_BIT],
		pin0_q[irq_meas_pkg::PIN_WAVE_BIT]};

	generate
		for (genvar i = 0; i < irq_meas_pkg::NUM_INPUTS; i++) begin : g_pin
			pin_edge_detect u_det (
				.core_clk   (core_clk),
				.reset_n    (reset_n),
				.pin        (det_pin[i]),
				.enable     (det_en[i]),
				.rising_sel (det_rise[i]),
				.level_sync (det_lvl[i]),
				.edge_pulse (det_edge[i])
			);
		end
	endgenerate

	// Period measurement sequencing
	always_comb begin
		meas_edge   = meas_ctl_q[irq_meas_pkg::MEAS_SRC_BIT] ? det_edge[2] : det_edge[0];
		meas_active = meas_ctl_q[irq_meas_pkg::MEAS_ENABLE_BIT];
		meas_hit    = 1'b0;
		meas_stop   = 1'b0;
		restart_d   = 1'b0;
		capture_d   = 1'b0;
		meas_d      = meas_q;
		case (meas_q)
			M_IDLE: begin
				if (meas_active) begin
					meas_d = M_WAIT_FIRST;
				end
			end
			M_WAIT_FIRST: begin
				if (!meas_active) begin
					meas_d = M_IDLE;
				end else if (meas_edge && timer1_running) begin
					meas_d    = M_TIMING;
					restart_d = 1'b1;
				end
			end
			M_TIMING: begin
				if (!meas_active) begin
					meas_d    = M_IDLE;
					meas_stop = 1'b1;
				end else if (meas_edge && timer1_running) begin
					meas_hit  = 1'b1;
					capture_d = 1'b1;
					restart_d = 1'b1;
				end
			end
			default: meas_d = M_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meas_q    <= M_IDLE;
			restart_q <= 1'b0;
			capture_q <= 1'b0;
		end else begin
			meas_q    <= meas_d;
			restart_q <= restart_d;
			capture_q <= capture_d;
		end
	end

	// Request flags; a set in the same cycle as a skip-test clear wins
	always_comb begin
		flag_set[irq_meas_pkg::FLAG_EXT0] = det_edge[0];
		flag_set[irq_meas_pkg::FLAG_EXT1] = det_edge[1];
		flag_set[irq_meas_pkg::FLAG_T1]   = (timer1_underflow & ~meas_active & meas_q == M_IDLE)
			| meas_hit | meas_stop;
		flag_clr = 3'h0;
		if (instr.valid) begin
			case (instr.op)
				irq_meas_pkg::OP_SKIP_EXT0: flag_clr[irq_meas_pkg::FLAG_EXT0] = 1'b1;
				irq_meas_pkg::OP_SKIP_EXT1: flag_clr[irq_meas_pkg::FLAG_EXT1] = 1'b1;
				irq_meas_pkg::OP_SKIP_T1:   flag_clr[irq_meas_pkg::FLAG_T1]   = 1'b1;
				default:                    flag_clr = 3'h0;
			endcase
		end
		flags_d = flag_set | (flags_q & ~flag_clr);
		skip_d  = |(flags_q & flag_clr);
	end

	// Power-off pair: the enable arms only until the very next instruction
	always_comb begin
		armed_d  = armed_q;
		backup_d = 1'b0;
		if (instr.valid) begin
			armed_d  = instr.op == irq_meas_pkg::OP_PWR_OFF_EN;
			backup_d = instr.op == irq_meas_pkg::OP_PWR_OFF && armed_q;
		end
		// Key-on wakeup is low-active on the pins and ignores the input enable
		wakeup_d = (wake_q[irq_meas_pkg::WAKE0_BIT] & ~det_lvl[0])
			| (wake_q[irq_meas_pkg::WAKE1_BIT] & ~det_lvl[1]);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q  <= irq_meas_pkg::FLAGS_RESET;
			skip_q   <= 1'b0;
			armed_q  <= 1'b0;
			backup_q <= 1'b0;
			wakeup_q <= 1'b0;
		end else begin
			flags_q  <= flags_d;
			skip_q   <= skip_d;
			armed_q  <= armed_d;
			backup_q <= backup_d;
			wakeup_q <= wakeup_d;
		end
	end

	assign ctl_state           = '{pin0_q, pin1_q, irq_en_q, meas_ctl_q, wake_q};
	assign ext0_request_flag   = flags_q[irq_meas_pkg::FLAG_EXT0];
	assign ext1_request_flag   = flags_q[irq_meas_pkg::FLAG_EXT1];
	assign timer1_request_flag = flags_q[irq_meas_pkg::FLAG_T1];
	assign irq_request         = flags_q & irq_en_q[2:0];
	assign skip_next           = skip_q;
	assign meas_restart        = restart_q;
	assign meas_capture        = capture_q;
	assign ram_backup_enter    = backup_q;
	assign keyon_wakeup        = wakeup_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_pwr_en;
		instr.valid && instr.op == irq_meas_pkg::OP_PWR_OFF_EN;
	endsequence
	sequence s_pwr_off;
		instr.valid && instr.op == irq_meas_pkg::OP_PWR_OFF;
	endsequence

	chk_capture_needs_timer: assert property ($rose(capture_q) |-> $past(timer1_running))
		else $error("measurement edge counted before timer ran");
	chk_stop_sets_flag: assert property (meas_q == M_TIMING && !meas_active
		|=> timer1_request_flag)
		else $error("stopping a running measurement did not set timer flag");
	chk_underflow_masked: assert property (meas_active && timer1_underflow && !meas_hit
		&& !meas_stop && !timer1_request_flag |=> !timer1_request_flag)
		else $error("underflow set timer flag during measurement");
	chk_capture_flag: assert property (meas_hit |=> timer1_request_flag && capture_q)
		else $error("completed period did not set timer flag");
	chk_enable0_edge: assert property ($rose(pin0_q[irq_meas_pkg::PIN_ENABLE_BIT])
		&& $stable(pin0_q[irq_meas_pkg::PIN_WAVE_BIT]) && $stable(det_lvl[0])
		&& det_lvl[0] == pin0_q[irq_meas_pkg::PIN_WAVE_BIT] |=> ext0_request_flag)
		else $error("pin 0 enable change missed flag");
	chk_wave0_edge: assert property ($changed(pin0_q[irq_meas_pkg::PIN_WAVE_BIT])
		&& $stable(pin0_q[irq_meas_pkg::PIN_ENABLE_BIT]) && pin0_q[irq_meas_pkg::PIN_ENABLE_BIT]
		&& $stable(det_lvl[0]) && det_lvl[0] == pin0_q[irq_meas_pkg::PIN_WAVE_BIT]
		|=> ext0_request_flag)
		else $error("pin 0 waveform change missed flag");
	chk_enable1_edge: assert property ($rose(pin1_q[irq_meas_pkg::PIN_ENABLE_BIT])
		&& $stable(pin1_q[irq_meas_pkg::PIN_WAVE_BIT]) && $stable(det_lvl[1])
		&& det_lvl[1] == pin1_q[irq_meas_pkg::PIN_WAVE_BIT] |=> ext1_request_flag)
		else $error("pin 1 enable change missed flag");
	chk_pwr_pair: assert property (s_pwr_en ##1 s_pwr_off |=> ram_backup_enter)
		else $error("power-off pair did not enter back-up");
	chk_pwr_lone: assert property ((s_pwr_off and !armed_q) |=> !ram_backup_enter)
		else $error("lone power-off entered back-up");
	chk_skip_clears: assert property (instr.valid && instr.op == irq_meas_pkg::OP_SKIP_EXT0
		&& ext0_request_flag && !det_edge[0] |=> skip_next && !ext0_request_flag)
		else $error("skip-test did not skip and clear");
endmodule

// [core/irq_meas_pkg.sv]
// Shared constants and types for the external interrupt and period measurement block
package irq_meas_pkg;
	localparam int           CTL_W           = 4;
	// Bit positions in the pin control registers
	localparam int           PIN_SYNC_BIT    = 0;
	localparam int           PIN_WAVE_BIT    = 2;
	localparam int           PIN_ENABLE_BIT  = 3;
	// Bit positions in the interrupt enable group
	localparam int           EN_EXT0_BIT     = 0;
	localparam int           EN_EXT1_BIT     = 1;
	localparam int           EN_T1_BIT       = 2;
	// Bit positions in the measurement control register
	localparam int           MEAS_SRC_BIT    = 0;
	localparam int           MEAS_ENABLE_BIT = 2;
	// Bit positions in the key-on wakeup control
	localparam int           WAKE0_BIT       = 0;
	localparam int           WAKE1_BIT       = 2;
	// Flag indices, matching the enable bit order
	localparam int           FLAG_EXT0       = 0;
	localparam int           FLAG_EXT1       = 1;
	localparam int           FLAG_T1         = 2;
	localparam int           NUM_FLAGS       = 3;
	localparam int           NUM_INPUTS      = 3;
	localparam int           SYNC_STAGES     = 2;
	localparam logic [3:0]   CTL_RESET       = 4'h0;
	localparam logic [2:0]   FLAGS_RESET     = 3'h0;

	typedef enum logic [2:0] {
		OP_OTHER,
		OP_SKIP_EXT0,
		OP_SKIP_EXT1,
		OP_SKIP_T1,
		OP_PWR_OFF_EN,
		OP_PWR_OFF
	} op_type;

	typedef struct packed {
		logic   valid;
		op_type op;
	} instr_type;

	typedef enum logic [2:0] {
		SEL_PIN0,
		SEL_PIN1,
		SEL_ENABLE,
		SEL_MEASURE,
		SEL_WAKEUP
	} reg_sel_type;

	typedef struct packed {
		logic             valid;
		reg_sel_type      sel;
		logic [CTL_W-1:0] data;
	} reg_write_type;

	typedef struct packed {
		logic [CTL_W-1:0] pin0_irq_control;
		logic [CTL_W-1:0] pin1_irq_control;
		logic [CTL_W-1:0] irq_enable_group1;
		logic [CTL_W-1:0] measure_timer_control;
		logic [CTL_W-1:0] wakeup_control;
	} ctl_state_type;
endpackage

// [core/pin_edge_detect.sv]
// Pin synchroniser and qualified active-edge detector
`timescale 1ns/1ps
module pin_edge_detect (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic pin,
	input  wire logic enable,
	input  wire logic rising_sel,
	output logic      level_sync,
	output logic      edge_pulse
);
	logic [irq_meas_pkg::SYNC_STAGES-1:0] sync_q;
	logic                                 qual_q;
	logic                                 qual_d;

	// Enable and polarity enter the qualified level, so changing either
	// can produce an edge just as a pin transition does
	always_comb begin
		qual_d = enable & (sync_q[1] ~^ rising_sel);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_q <= '0;
			qual_q <= 1'b0;
		end else begin
			sync_q <= {sync_q[0], pin};
			qual_q <= qual_d;
		end
	end

	assign level_sync = sync_q[1];
	assign edge_pulse = qual_d & ~qual_q;
endmodule

// [tb/ext_interrupt_period_measure_bench.sv]
// Self-checking bench for the external interrupt and period measurement block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %0t mismatch at line %0d", $time, `__LINE__); end end
module ext_interrupt_period_measure_bench;
	logic                         core_clk = 1'b0;
	logic                         reset_n = 1'b0;
	logic                         p0, p1, cnt;
	logic                         run = 1'b0;
	logic                         ufl = 1'b0;
	irq_meas_pkg::instr_type      instr = '0;
	irq_meas_pkg::reg_write_type  reg_write = '0;
	irq_meas_pkg::ctl_state_type  ctl;
	logic                         f0, f1, ft, skip, rst_p, cap_p, ram_p, wake;
	logic [2:0]                   irq;
	int                           fails = 0;
	int                           checks = 0;
	int                           n_rst = 0;
	int                           n_cap = 0;
	int                           n_ram = 0;

	always #2 core_clk = ~core_clk;

	pin_source u_src (.ext_irq_pin0(p0), .ext_irq_pin1(p1), .counter_input_pin(cnt));

	ext_interrupt_period_measure u_dut (
		.core_clk(core_clk), .reset_n(reset_n), .ext_irq_pin0(p0), .ext_irq_pin1(p1),
		.counter_input_pin(cnt), .timer1_running(run), .timer1_underflow(ufl),
		.instr(instr), .reg_write(reg_write), .ctl_state(ctl), .ext0_request_flag(f0),
		.ext1_request_flag(f1), .timer1_request_flag(ft), .irq_request(irq),
		.skip_next(skip), .meas_restart(rst_p), .meas_capture(cap_p),
		.ram_backup_enter(ram_p), .keyon_wakeup(wake)
	);

	// One-cycle pulses are tallied so a test can compare counts afterwards
	always @(posedge core_clk) begin
		if (rst_p === 1'b1) n_rst++;
		if (cap_p === 1'b1) n_cap++;
		if (ram_p === 1'b1) n_ram++;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input irq_meas_pkg::reg_sel_type s, input logic [3:0] d);
		@(posedge core_clk);
		reg_write <= '{1'b1, s, d};
		@(posedge core_clk);
		reg_write <= '0;
		#1;
	endtask
	task automatic op(input irq_meas_pkg::op_type o);
		@(posedge core_clk);
		instr <= '{1'b1, o};
		@(posedge core_clk);
		instr <= '0;
		#1;
	endtask
	task automatic pin(input int idx, input logic v);
		u_src.set(idx, v);
		cyc(6);
	endtask
	task automatic done(input string name);
		$display("test %s done", name);
	endtask
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#20000;
		fails++;
		results();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		cyc(1);
		`CHK(ctl, '0)
		`CHK({f0, f1, ft, skip, wake}, 5'h00)
		done("reset");
		wr(irq_meas_pkg::SEL_ENABLE, 4'h0);
		wr(irq_meas_pkg::SEL_PIN0, 4'hc);
		cyc(3);
		`CHK(ctl.pin0_irq_control, 4'hc)
		`CHK(f0, 1'b1)
		op(irq_meas_pkg::OP_SKIP_EXT0);
		`CHK({skip, f0}, 2'b10)
		op(irq_meas_pkg::OP_SKIP_EXT0);
		`CHK(skip, 1'b0)
		done("pin0 enable");
		pin(0, 1'b0);
		`CHK(f0, 1'b0)
		wr(irq_meas_pkg::SEL_PIN0, 4'h8);
		cyc(3);
		`CHK(f0, 1'b1)
		op(irq_meas_pkg::OP_SKIP_EXT0);
		`CHK(f0, 1'b0)
		wr(irq_meas_pkg::SEL_PIN0, 4'h0);
		wr(irq_meas_pkg::SEL_PIN0, 4'h8);
		cyc(3);
		`CHK(f0, 1'b1)
		op(irq_meas_pkg::OP_SKIP_EXT0);
		`CHK({skip, f0}, 2'b10)
		done("pin0 wave");
		wr(irq_meas_pkg::SEL_PIN1, 4'hc);
		cyc(3);
		`CHK(f1, 1'b1)
		op(irq_meas_pkg::OP_SKIP_EXT1);
		`CHK({skip, f1}, 2'b10)
		wr(irq_meas_pkg::SEL_PIN1, 4'h8);
		cyc(3);
		`CHK(f1, 1'b0)
		pin(1, 1'b0);
		`CHK(f1, 1'b1)
		wr(irq_meas_pkg::SEL_ENABLE, 4'h2);
		`CHK(irq, 3'b010)
		wr(irq_meas_pkg::SEL_ENABLE, 4'h0);
		op(irq_meas_pkg::OP_SKIP_EXT1);
		`CHK(f1, 1'b0)
		wr(irq_meas_pkg::SEL_PIN1, 4'h0);
		wr(irq_meas_pkg::SEL_PIN1, 4'h8);
		cyc(3);
		`CHK(f1, 1'b1)
		op(irq_meas_pkg::OP_SKIP_EXT1);
		`CHK({skip, f1}, 2'b10)
		done("pin1");
		wr(irq_meas_pkg::SEL_WAKEUP, 4'h1);
		cyc(2);
		`CHK(wake, 1'b1)
		wr(irq_meas_pkg::SEL_WAKEUP, 4'h4);
		cyc(2);
		`CHK(wake, 1'b1)
		wr(irq_meas_pkg::SEL_WAKEUP, 4'h0);
		cyc(2);
		`CHK(wake, 1'b0)
		done("wakeup");
		wr(irq_meas_pkg::SEL_MEASURE, 4'h5);
		pin(2, 1'b1);
		pin(2, 1'b0);
		`CHK(n_rst, 0)
		@(posedge core_clk);
		run <= 1'b1;
		pin(2, 1'b1);
		pin(2, 1'b0);
		`CHK({n_rst, n_cap}, {32'd1, 32'd0})
		@(posedge core_clk);
		ufl <= 1'b1;
		@(posedge core_clk);
		ufl <= 1'b0;
		cyc(3);
		`CHK(ft, 1'b0)
		pin(2, 1'b1);
		`CHK({n_rst, n_cap}, {32'd2, 32'd1})
		`CHK(ft, 1'b1)
		op(irq_meas_pkg::OP_SKIP_T1);
		`CHK({skip, ft}, 2'b10)
		@(posedge core_clk);
		run <= 1'b0;
		wr(irq_meas_pkg::SEL_MEASURE, 4'h1);
		cyc(2);
		`CHK(ft, 1'b1)
		op(irq_meas_pkg::OP_SKIP_T1);
		`CHK(ft, 1'b0)
		// Pin 0 as measured input, falling edges counted
		wr(irq_meas_pkg::SEL_PIN0, 4'h8);
		wr(irq_meas_pkg::SEL_MEASURE, 4'h4);
		@(posedge core_clk);
		run <= 1'b1;
		pin(0, 1'b1);
		pin(0, 1'b0);
		pin(0, 1'b1);
		pin(0, 1'b0);
		`CHK({n_rst, n_cap}, {32'd4, 32'd2})
		`CHK({ft, f0}, 2'b11)
		@(posedge core_clk);
		run <= 1'b0;
		wr(irq_meas_pkg::SEL_MEASURE, 4'h0);
		cyc(2);
		op(irq_meas_pkg::OP_SKIP_T1);
		`CHK({skip, ft}, 2'b10)
		op(irq_meas_pkg::OP_SKIP_EXT0);
		`CHK(f0, 1'b0)
		// Outside measurement an underflow is an ordinary timer request
		@(posedge core_clk);
		ufl <= 1'b1;
		@(posedge core_clk);
		ufl <= 1'b0;
		cyc(2);
		`CHK(ft, 1'b1)
		op(irq_meas_pkg::OP_SKIP_T1);
		`CHK({skip, ft}, 2'b10)
		done("measure");
		op(irq_meas_pkg::OP_PWR_OFF);
		op(irq_meas_pkg::OP_PWR_OFF_EN);
		op(irq_meas_pkg::OP_OTHER);
		op(irq_meas_pkg::OP_PWR_OFF);
		cyc(2);
		`CHK(n_ram, 0)
		op(irq_meas_pkg::OP_PWR_OFF_EN);
		op(irq_meas_pkg::OP_PWR_OFF);
		cyc(2);
		`CHK(n_ram, 1)
		// Pair on consecutive instruction slots
		@(posedge core_clk);
		instr <= '{1'b1, irq_meas_pkg::OP_PWR_OFF_EN};
		@(posedge core_clk);
		instr <= '{1'b1, irq_meas_pkg::OP_PWR_OFF};
		@(posedge core_clk);
		instr <= '0;
		cyc(2);
		`CHK(n_ram, 2)
		done("power off");
		results();
	end
endmodule

// [tb/pin_source.sv]
// Behavioural signal sources on the interrupt and counter pins
`timescale 1ns/1ps
module pin_source (
	output logic ext_irq_pin0,
	output logic ext_irq_pin1,
	output logic counter_input_pin
);
	initial begin
		ext_irq_pin0      = 1'b1;
		ext_irq_pin1      = 1'b1;
		counter_input_pin = 1'b0;
	end
	// Sources are asynchronous: change mid-cycle, clear of the sampling edge
	task automatic set(input int idx, input logic v);
		#1.3;
		case (idx)
			0: ext_irq_pin0 = v;
			1: ext_irq_pin1 = v;
			default: counter_input_pin = v;
		endcase
	endtask
endmodule
